//--- hw/psr_defs.svh
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// Register map, byte addresses within the system control window
`define PSR_SYSCTL_BASE      32'h400f_e000
`define PSR_OFF_SOFT_RESET   12'h048
`define PSR_OFF_CAP_MASK     12'h050
`define PSR_ADDR_W           12

// Field layout
`define PSR_NUM_PORTS        5
`define PSR_PORT_LSB         0
`define PSR_PORT_MSB         4

// Reset values
`define PSR_SOFT_RESET_RST   5'h00
`define PSR_CAP_MASK_RST     5'h1f

`endif

//--- hw/psr_pkg.sv
package psr_pkg;
   typedef logic [4:0] psr_ports_t;
   typedef enum logic [1:0] {
      PSR_IDLE,
      PSR_ANSWER
   } psr_state_t;
endpackage

//--- hw/psr_port_soft_reset.sv
`timescale 1ns/1ps
`include "psr_defs.svh"

// Function
// - Writes to port reset bits are masked bit by bit by the capability register.
// - Port reset register decodes at offset 0x048 from base 0x400F.E000.
// - Bits 31:5 read as zero and ignore writes.
// - Bits 0..4 are read/write reset controls for ports A..E, zero at reset.
module psr_port_soft_reset
   import psr_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic [11:0]  avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [31:0]  avs_writedata,
   input  wire logic [3:0]   avs_byteenable,
   output logic      [31:0]  avs_readdata,
   output logic              avs_waitrequest,
   output logic      [1:0]   avs_response,
   output logic              port_a_reset_bit,
   output logic              port_b_reset_bit,
   output logic              port_c_reset_bit,
   output logic              port_d_reset_bit,
   output logic              port_e_reset_bit
);

   // ------------------------------------------------------------
   // Reset synchroniser
   // ------------------------------------------------------------
   logic       rst_meta_r;
   logic       rst_n_r;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Bus slave and registers
   // ------------------------------------------------------------
   psr_state_t  state_r,     state_nxt;
   psr_ports_t  soft_rst_r,  soft_rst_nxt;
   psr_ports_t  cap_mask_r,  cap_mask_nxt;
   logic [31:0] rdata_r,     rdata_nxt;
   logic [1:0]  resp_r,      resp_nxt;

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      return addr == off;
   endfunction

   // Only byte lane 0 carries implemented bits
   logic        lane0_wr;
   assign lane0_wr = avs_write && avs_byteenable[0];

   always_comb begin
      state_nxt    = state_r;
      soft_rst_nxt = soft_rst_r;
      cap_mask_nxt = cap_mask_r;
      rdata_nxt    = rdata_r;
      resp_nxt     = resp_r;
      unique case (state_r)
         PSR_IDLE: begin
            // One wait state: request accepted at the following edge
            if (avs_read || avs_write) begin
               state_nxt = PSR_ANSWER;
               rdata_nxt = 32'h0000_0000;
               resp_nxt  = 2'h0;
               if (hit(avs_address, `PSR_OFF_SOFT_RESET)) begin
                  if (avs_read)
                     rdata_nxt[`PSR_PORT_MSB:`PSR_PORT_LSB] = soft_rst_r;
                  else if (lane0_wr)
                     soft_rst_nxt = (soft_rst_r & ~cap_mask_r)
                        | (avs_writedata[`PSR_PORT_MSB:`PSR_PORT_LSB]
                           & cap_mask_r);
               end else if (hit(avs_address, `PSR_OFF_CAP_MASK)) begin
                  if (avs_read)
                     rdata_nxt[`PSR_PORT_MSB:`PSR_PORT_LSB] = cap_mask_r;
                  else if (lane0_wr)
                     cap_mask_nxt = avs_writedata[`PSR_PORT_MSB:`PSR_PORT_LSB];
               end else begin
                  // Unmapped: decode error, writes dropped, reads zero
                  resp_nxt = 2'h3;
               end
            end
         end
         PSR_ANSWER: begin
            state_nxt = PSR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r    <= PSR_IDLE;
         soft_rst_r <= `PSR_SOFT_RESET_RST;
         cap_mask_r <= `PSR_CAP_MASK_RST;
         rdata_r    <= 32'h0000_0000;
         resp_r     <= 2'h0;
      end else begin
         state_r    <= state_nxt;
         soft_rst_r <= soft_rst_nxt;
         cap_mask_r <= cap_mask_nxt;
         rdata_r    <= rdata_nxt;
         resp_r     <= resp_nxt;
      end
   end

   assign avs_waitrequest = !(state_r == PSR_ANSWER);
   assign avs_readdata    = rdata_r;
   assign avs_response    = resp_r;

   // ------------------------------------------------------------
   // Port reset outputs
   // ------------------------------------------------------------
   // Held for as long as the bit stays set
   assign port_a_reset_bit = soft_rst_r[0];
   assign port_b_reset_bit = soft_rst_r[1];
   assign port_c_reset_bit = soft_rst_r[2];
   assign port_d_reset_bit = soft_rst_r[3];
   assign port_e_reset_bit = soft_rst_r[4];

endmodule

//--- bench/psr_monitor.sv
`timescale 1ns/1ps
module psr_monitor (
   input logic        clk_sys,
   input logic        nrst,
   input logic [11:0] avs_address,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic [1:0]  avs_response,
   input logic        port_a_reset_bit,
   input logic        port_b_reset_bit,
   input logic        port_c_reset_bit,
   input logic        port_d_reset_bit,
   input logic        port_e_reset_bit
);
   logic [4:0] pv;
   assign pv = {port_e_reset_bit, port_d_reset_bit, port_c_reset_bit, port_b_reset_bit,
                port_a_reset_bit};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence rd_s; avs_read && !avs_waitrequest; endsequence
   one_wait_a: assert property (req_s |=> !avs_waitrequest) else $error("no answer");
   rsv_zero_a: assert property (rd_s |-> avs_readdata[31:5] == 27'h0) else $error("rsv");
   bad_addr_a: assert property (rd_s and avs_address != 12'h048 and avs_address != 12'h050
      |-> avs_response == 2'h3) else $error("decode");
   read_back_a: assert property (rd_s and avs_address == 12'h048
      |-> avs_readdata[4:0] == pv) else $error("readback");
   port_hold_a: assert property (!$stable(pv) |-> $past(avs_write && avs_waitrequest
      && avs_address == 12'h048)) else $error("port moved");
endmodule
bind psr_port_soft_reset psr_monitor i_mon (.*);

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb_top;
   import psr_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [4:0] x;} psr_row_t;
   logic        clk_sys = 0;
   logic        nrst = 0;
   logic        rd = 0;
   logic        wr = 0;
   logic [11:0] ad = 0;
   logic [31:0] wd = 0;
   logic [31:0] rdat;
   logic [3:0]  be = 4'hf;
   wire  [31:0] rdata;
   wire         wt;
   wire  [1:0]  resp;
   wire  [4:0]  pv;
   int          err_total = 0;
   int          tests_run = 0;
   // Mask 0x05 leaves ports b, d and e frozen in the middle rows
   psr_row_t rows [7] = '{'{12'h048, 32'h1f, 5'h1f}, '{12'h048, 32'hffff_ffea, 5'h0a},
      '{12'h050, 32'h05, 5'h05}, '{12'h048, 32'h1f, 5'h0f}, '{12'h048, 32'h0, 5'h0a},
      '{12'h100, 32'hffff_ffff, 5'h0}, '{12'h050, 32'h1f, 5'h1f}};
   always #50 clk_sys = ~clk_sys;
   psr_port_soft_reset i_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(ad),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdata), .avs_waitrequest(wt), .avs_response(resp),
      .port_a_reset_bit(pv[0]), .port_b_reset_bit(pv[1]), .port_c_reset_bit(pv[2]),
      .port_d_reset_bit(pv[3]), .port_e_reset_bit(pv[4]));
   task give_verdict;
      if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Answer taken at the rising edge that sees waitrequest low, released at that edge
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= w;
      rd <= !w;
      ad <= a;
      wd <= d;
      do @(posedge clk_sys); while (wt);
      rdat = rdata;
      wr <= 0;
      rd <= 0;
   endtask
   initial begin
      #1000000;
      err_total++;
      give_verdict;
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1;
      repeat (3) @(posedge clk_sys);
      foreach (rows[i]) begin
         bus(1, rows[i].a, rows[i].d);
         bus(0, rows[i].a, 32'h0);
         `CHK(rdat, {27'h0, rows[i].x})
         `CHK(resp, (rows[i].a == 12'h100) ? 2'h3 : 2'h0)
         if (rows[i].a == 12'h048) `CHK(pv, rows[i].x)
      end
      be <= 4'he;
      bus(1, 12'h048, 32'h1f);
      be <= 4'hf;
      bus(0, 12'h048, 32'h0);
      `CHK(rdat, 32'h0a)
      nrst <= 0;
      @(negedge clk_sys);
      `CHK(pv, 5'h0)
      repeat (2) @(posedge clk_sys);
      nrst <= 1;
      repeat (3) @(posedge clk_sys);
      bus(0, 12'h048, 32'h0);
      `CHK(rdat, 32'h0)
      // Read-modify-write keeps the reserved bits as read
      bus(1, 12'h048, {rdat[31:5], 5'h04});
      bus(0, 12'h048, 32'h0);
      `CHK(rdat, 32'h04)
      `CHK(pv, 5'h04)
      give_verdict;
   end
endmodule
